// [core/pets_regs.svh]
`ifndef PETS_REGS_SVH
`define PETS_REGS_SVH

// ==========================================================
// register map
`define PETS_CFG_REGION 3'h2
`define PETS_CAP_OFF 12'hD88
`define PETS_SEC_OFF 12'hE80
`define PETS_HIT_OFF 12'hE84

// ==========================================================
// field positions and reset values
`define PETS_OVERFLOW_CAPTURE_ENABLE_BIT 31
`define PETS_TYPE_HI 17
`define PETS_TYPE_LO 16
`define PETS_CODE_HI 7
`define PETS_TYPE_COUNT 2'h0
`define PETS_TYPE_MAX 2'h2
`define PETS_TYPE_RST 2'h0
`define PETS_CAP_BIT 0
`define PETS_SPF_BIT 1'h0
`define PETS_DS_BIT 1'h1

// ==========================================================
// event codes
`define PETS_NUM_EV 21
`define PETS_EV_CLK 8'h00
`define PETS_EV_NO_GATE 8'h01
`define PETS_EV_DN_MSG 8'h04
`define PETS_EV_DN_SET 8'h05
`define PETS_EV_ONE_OF_N 8'h06
`define PETS_EV_UP_MSG 8'h08
`define PETS_EV_UP_ACT 8'h09
`define PETS_EV_UP_REL 8'h0A
`define PETS_EV_UP_ACT_LOC 8'h0B
`define PETS_EV_SET_ACT 8'h0C
`define PETS_EV_UPSTREAM_DEACTIVATE_EVENT 8'h0D
`define PETS_EV_UP_DBL 8'h0E
`define PETS_EV_SOFT_BRD 8'h10
`define PETS_EV_SOFT_ACC 8'h13
`define PETS_EV_REMOTE_BRD 8'h14

`endif

// [core/pets_pkg.sv]
`default_nettype none
`include "pets_regs.svh"

package pets_pkg;

    // one counter's configuration
    typedef struct packed {
        logic ovf_cap;
        logic [1:0] track_type;
        logic [7:0] code;
    } pets_cfg_t;

    // event strobes, indexed by event code
    typedef struct packed {
        logic [`PETS_NUM_EV-1:0] fire;
        logic [`PETS_NUM_EV-1:0] secure;
        logic set_comp_release;
        logic release_secure;
    } pets_evt_t;

    // per-counter commands toward the counter logic
    typedef struct packed {
        logic inc;
        logic dec;
        logic max_mode;
        logic capture;
    } pets_cnt_ctl_t;

    typedef enum logic {
        PETS_BUS_IDLE = 1'b0,
        PETS_BUS_ACK = 1'b1
    } pets_bus_state_t;

endpackage
`default_nettype wire

// [core/pets_cfg_reg.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pets_regs.svh"

module pets_cfg_reg (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] be_i,
    output pets_pkg::pets_cfg_t cfg_o,
    output logic written_o
);
    import pets_pkg::*;

    logic ovf_cap_q, ovf_cap_d;
    logic [1:0] type_q, type_d;
    logic [7:0] code_q, code_d;
    logic written_q, written_d;

    always_comb begin
        ovf_cap_d = ovf_cap_q;
        type_d = type_q;
        code_d = code_q;
        written_d = written_q;
        if (wr_i && be_i[3]) begin
            ovf_cap_d = wdata_i[`PETS_OVERFLOW_CAPTURE_ENABLE_BIT];
        end
        if (wr_i && be_i[2]) begin
            type_d = wdata_i[`PETS_TYPE_HI:`PETS_TYPE_LO];
        end
        if (wr_i && be_i[0]) begin
            code_d = wdata_i[`PETS_CODE_HI:0];
            written_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf_cap_q <= 1'b0;
            type_q <= `PETS_TYPE_RST;
            written_q <= 1'b0;
        end else begin
            ovf_cap_q <= ovf_cap_d;
            type_q <= type_d;
            written_q <= written_d;
        end
    end

    // event code is left unreset on purpose; its reset value is unknown
    always_ff @(posedge clk_i) begin
        code_q <= code_d;
    end

    assign cfg_o = '{ovf_cap: ovf_cap_q, track_type: type_q, code: code_q};
    assign written_o = written_q;

endmodule
`default_nettype wire

// [core/pets_event_select.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pets_regs.svh"

module pets_event_select (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire pets_pkg::pets_cfg_t cfg_i,
    input wire logic written_i,
    input wire logic cnt_en_i,
    input wire logic filter_hit_i,
    input wire logic overflow_i,
    input wire logic cap_ctl_i,
    input wire logic spf_i,
    input wire logic ds_i,
    input wire pets_pkg::pets_evt_t evt_i,
    output pets_pkg::pets_cnt_ctl_t ctl_o
);
    import pets_pkg::*;

    // {valid, maskable, filtered}
    function automatic logic [2:0] code_class(input logic [7:0] code);
        case (code)
            `PETS_EV_CLK, `PETS_EV_NO_GATE: code_class = 3'h4;
            `PETS_EV_DN_MSG, `PETS_EV_UP_MSG: code_class = 3'h7;
            `PETS_EV_DN_SET, `PETS_EV_ONE_OF_N: code_class = 3'h7;
            `PETS_EV_UP_ACT, `PETS_EV_UP_REL: code_class = 3'h7;
            `PETS_EV_UP_ACT_LOC: code_class = 3'h5;
            `PETS_EV_SET_ACT, `PETS_EV_UPSTREAM_DEACTIVATE_EVENT: code_class = 3'h7;
            `PETS_EV_UP_DBL: code_class = 3'h5;
            `PETS_EV_REMOTE_BRD: code_class = 3'h7;
            default: begin
                if (code >= `PETS_EV_SOFT_BRD && code <= `PETS_EV_SOFT_ACC) begin
                    code_class = 3'h7;
                end else begin
                    code_class = 3'h0;
                end
            end
        endcase
    endfunction

    pets_cnt_ctl_t ctl_q, ctl_d;
    logic [2:0] cls;
    logic [31:0] fire_w, sec_w;
    logic hit, masked, filt_ok, type_ok, live, suppress;

    always_comb begin
        cls = code_class(cfg_i.code);
        fire_w = {11'h0, evt_i.fire};
        sec_w = {11'h0, evt_i.secure};
        suppress = spf_i && !ds_i;
        hit = (cfg_i.code == `PETS_EV_CLK) || fire_w[cfg_i.code[4:0]];
        masked = cls[1] && suppress && sec_w[cfg_i.code[4:0]];
        filt_ok = !cls[0] || filter_hit_i;
        type_ok = (cfg_i.track_type == `PETS_TYPE_COUNT) ||
                  (cfg_i.track_type == `PETS_TYPE_MAX);
        live = written_i && cnt_en_i && type_ok && cls[2];
        ctl_d.inc = live && hit && !masked && filt_ok;
        // the set-then-activate count walks back down on release
        ctl_d.dec = live && (cfg_i.code == `PETS_EV_SET_ACT) && evt_i.set_comp_release &&
                    !(suppress && evt_i.release_secure) && filt_ok;
        ctl_d.max_mode = written_i && (cfg_i.track_type == `PETS_TYPE_MAX);
        ctl_d.capture = written_i && cfg_i.ovf_cap && cap_ctl_i && overflow_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= '0;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign ctl_o = ctl_q;

endmodule
`default_nettype wire

// [core/pets_top.sv]
// Contract
// - five counters 0 to 4, each with its own event configuration register
// - overflow with capture bit and global capture set triggers shadow capture
// - tracking type 00 counts, 10 tracks maximum, 01 and 11 reserved
// - bits 7:0 hold event code, unknown after reset
// - configuration register of an unimplemented counter reads zero, ignores writes
// - maskable secure events suppressed only when filter bit 1, disable-security 0
// - code 0 counts every cycle, code 1 no-gate cycles, no filter
// - code 4 counts downstream messages, always maskable, target filtered
// - code 5 counts set messages, masked for secure groups, filtered
// - code 6 counts one-of-N sets, masked for secure groups, filtered
// - code 8 counts upstream messages, always maskable, target filtered
// - codes 9, A, B count activates, releases, local activates; B unmasked
// - code C increments on set-then-activate, decrements on release
// - code D counts shared deactivates, masked for secure groups
// - code E counts doorbell activates, never masked, filtered
// - codes 10 to 13 count software interrupts, masked when non-secure 0
// - code 14 counts remote broadcasts, filtered, masked when non-secure 0
// - enabled counter increments when an event matching its code occurs
// - global capture control is write-only at offset D88
`timescale 1ns/1ps
`default_nettype none
`include "pets_regs.svh"

module pets_top #(
    parameter int NUM_CNT = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // ==========================================================
    // avalon-mm slave, byte addressed
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // ==========================================================
    // event side
    input wire pets_pkg::pets_evt_t evt_i,
    input wire logic [NUM_CNT-1:0] cnt_en_i,
    input wire logic [NUM_CNT-1:0] filter_hit_i,
    input wire logic [NUM_CNT-1:0] overflow_i,
    output pets_pkg::pets_cnt_ctl_t [NUM_CNT-1:0] cnt_ctl_o
);
    import pets_pkg::*;

    // ==========================================================
    // address decode

    // index of a configuration slot, or all ones when outside the window
    function automatic logic [7:0] cfg_slot(input logic [11:0] addr);
        if (addr[11:9] == `PETS_CFG_REGION) begin
            cfg_slot = {1'b0, addr[8:2]};
        end else begin
            cfg_slot = 8'hFF;
        end
    endfunction

    function automatic logic is_impl(input logic [7:0] slot);
        is_impl = (slot != 8'hFF) && (32'(slot) < NUM_CNT);
    endfunction

    // ==========================================================
    // bus handshake
    // every access takes one wait cycle; a write lands at the edge where
    // waitrequest is seen low, so master and slave agree on the instant

    pets_bus_state_t st_q, st_d;
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic commit_wr;
    logic [7:0] acc_slot;
    logic [31:0] read_word;

    always_comb begin
        st_d = st_q;
        wait_d = wait_q;
        rdata_d = rdata_q;
        case (st_q)
            PETS_BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    st_d = PETS_BUS_ACK;
                    wait_d = 1'b0;
                    rdata_d = avs_read_i ? read_word : 32'h0;
                end
            end
            PETS_BUS_ACK: begin
                st_d = PETS_BUS_IDLE;
                wait_d = 1'b1;
            end
            default: begin
                st_d = PETS_BUS_IDLE;
                wait_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= PETS_BUS_IDLE;
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            st_q <= st_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign commit_wr = (st_q == PETS_BUS_ACK) && avs_write_i;
    assign acc_slot = cfg_slot(avs_address_i);
    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;

    // ==========================================================
    // global controls

    logic cap_ctl_q, cap_ctl_d;
    logic spf_q, spf_d;
    logic ds_q, ds_d;
    logic [NUM_CNT-1:0] hit_q, hit_d;
    logic [NUM_CNT-1:0] inc_seen;

    always_comb begin
        cap_ctl_d = cap_ctl_q;
        spf_d = spf_q;
        ds_d = ds_q;
        hit_d = hit_q;
        if (commit_wr && avs_byteenable_i[0]) begin
            if (avs_address_i == `PETS_CAP_OFF) begin
                cap_ctl_d = avs_writedata_i[`PETS_CAP_BIT];
            end
            if (avs_address_i == `PETS_SEC_OFF) begin
                spf_d = avs_writedata_i[`PETS_SPF_BIT];
                ds_d = avs_writedata_i[`PETS_DS_BIT];
            end
            if (avs_address_i == `PETS_HIT_OFF) begin
                hit_d = hit_q & ~avs_writedata_i[NUM_CNT-1:0];
            end
        end
        // a new increment beats a clear in the same cycle
        hit_d = hit_d | inc_seen;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_ctl_q <= 1'b0;
            spf_q <= 1'b0;
            ds_q <= 1'b0;
            hit_q <= '0;
        end else begin
            cap_ctl_q <= cap_ctl_d;
            spf_q <= spf_d;
            ds_q <= ds_d;
            hit_q <= hit_d;
        end
    end

    // ==========================================================
    // per-counter configuration and event selection

    pets_cfg_t cfg [NUM_CNT];
    logic [NUM_CNT-1:0] written;
    logic [31:0] cfg_word [NUM_CNT];

    for (genvar n = 0; n < NUM_CNT; n++) begin : g_cnt
        logic wr_n;

        assign wr_n = commit_wr && (acc_slot == 8'(n));

        pets_cfg_reg u_cfg (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .wr_i(wr_n),
            .wdata_i(avs_writedata_i),
            .be_i(avs_byteenable_i),
            .cfg_o(cfg[n]),
            .written_o(written[n])
        );

        pets_event_select u_sel (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .cfg_i(cfg[n]),
            .written_i(written[n]),
            .cnt_en_i(cnt_en_i[n]),
            .filter_hit_i(filter_hit_i[n]),
            .overflow_i(overflow_i[n]),
            .cap_ctl_i(cap_ctl_q),
            .spf_i(spf_q),
            .ds_i(ds_q),
            .evt_i(evt_i),
            .ctl_o(cnt_ctl_o[n])
        );

        // reserved bits are never stored, so they read back as zero
        assign cfg_word[n] = {cfg[n].ovf_cap, 13'h0, cfg[n].track_type,
                              8'h0, cfg[n].code};
        assign inc_seen[n] = cnt_ctl_o[n].inc;
    end

    // ==========================================================
    // read multiplexer

    always_comb begin
        read_word = 32'h0;
        if (is_impl(acc_slot)) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                if (acc_slot == 8'(i)) begin
                    read_word = cfg_word[i];
                end
            end
        end else if (avs_address_i == `PETS_SEC_OFF) begin
            read_word[`PETS_SPF_BIT] = spf_q;
            read_word[`PETS_DS_BIT] = ds_q;
        end else if (avs_address_i == `PETS_HIT_OFF) begin
            read_word[NUM_CNT-1:0] = hit_q;
        end
        // capture control is write-only and reads zero, as do unused slots
    end

endmodule
`default_nettype wire

// [testbench/pets_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none

module pets_top_sva #(
    parameter int NUM_CNT = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire pets_pkg::pets_evt_t evt_i,
    input wire logic [NUM_CNT-1:0] cnt_en_i,
    input wire logic [NUM_CNT-1:0] filter_hit_i,
    input wire logic [NUM_CNT-1:0] overflow_i,
    input wire pets_pkg::pets_cnt_ctl_t [NUM_CNT-1:0] cnt_ctl_o
);
    import pets_pkg::*;
    logic [NUM_CNT-1:0] inc_w;
    logic [NUM_CNT-1:0] dec_w;
    logic [NUM_CNT-1:0] cap_w;
    logic any_wr_d;
    logic any_wr_q;
    logic rd_go;

    // ==========
    // helpers
    always_comb begin
        for (int i = 0; i < NUM_CNT; i++) begin
            inc_w[i] = cnt_ctl_o[i].inc;
            dec_w[i] = cnt_ctl_o[i].dec;
            cap_w[i] = cnt_ctl_o[i].capture;
        end
    end
    // any configuration write opens the gate; slot detail is left to the bench
    always_comb begin
        any_wr_d = any_wr_q;
        if (rst_i) begin
            any_wr_d = 1'b0;
        end else if (avs_write_i && !avs_waitrequest_o && avs_address_i[11:9] == 3'h2) begin
            any_wr_d = 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        any_wr_q <= any_wr_d;
    end
    assign rd_go = avs_read_i && avs_waitrequest_o;

    // ==========
    // properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    wait_one_a: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("access not answered after one wait cycle");
    wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer held longer than one cycle");
    reset_quiet_a: assert property (disable iff (1'b0)
        rst_i |=> avs_waitrequest_o && avs_readdata_o == 32'h0 && cnt_ctl_o == '0)
        else $error("outputs not quiet under reset");
    capture_reads_a: assert property (
        rd_go && avs_address_i == 12'hD88 |=> avs_readdata_o == 32'h0)
        else $error("capture control readable");
    unimpl_zero_a: assert property (
        rd_go && avs_address_i >= 12'h414 && avs_address_i <= 12'h5FF |=> avs_readdata_o == 32'h0)
        else $error("missing counter slot reads nonzero");
    rsvd_bits_a: assert property (
        rd_go && avs_address_i[11:9] == 3'h2 |=> (avs_readdata_o & 32'h7FFC_FF00) == 32'h0)
        else $error("reserved config bits read nonzero");
    inc_enable_a: assert property ((inc_w & ~$past(cnt_en_i)) == '0)
        else $error("increment from a disabled counter");
    cap_cause_a: assert property ((cap_w & ~$past(overflow_i)) == '0)
        else $error("capture without overflow");
    dec_cause_a: assert property (|dec_w |-> $past(evt_i.set_comp_release)
        && (dec_w & ~($past(cnt_en_i) & $past(filter_hit_i))) == '0)
        else $error("decrement without enabled filtered release");
    unwritten_quiet_a: assert property (!any_wr_q |-> inc_w == '0 && cap_w == '0)
        else $error("counter active before its configuration was written");

    cover property (|inc_w);
    cover property (|dec_w);
    cover property (|cap_w);
    cover property (rd_go && avs_address_i[11:9] == 3'h2);
endmodule

bind pets_top pets_top_sva #(.NUM_CNT(NUM_CNT)) u_pets_sva (
    .clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .evt_i, .cnt_en_i,
    .filter_hit_i, .overflow_i, .cnt_ctl_o
);

`default_nettype wire

// [testbench/tb_pets_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_pets_top;
    import pets_pkg::*;
    localparam int NC = 5;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [11:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = '0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    pets_evt_t evt_i = '0;
    logic [NC-1:0] cnt_en_i = '0;
    logic [NC-1:0] filter_hit_i = '0;
    logic [NC-1:0] overflow_i = '0;
    pets_cnt_ctl_t [NC-1:0] cnt_ctl_o;
    pets_cnt_ctl_t [NC-1:0] exp_q;
    logic [31:0] m_w [NC];
    logic [31:0] wc [NC];
    logic [NC-1:0] m_wr;
    logic [NC-1:0] m_hit;
    logic [NC-1:0] hit_snap = '0;
    logic [1:0] m_ctl;
    logic m_cap;
    logic live_q = 1'b0;
    logic [31:0] rd;
    int error_cnt = 0;
    int check_count = 0;

    always #4 clk_i = ~clk_i;

    pets_top #(.NUM_CNT(NC)) dut (
        .clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .evt_i,
        .cnt_en_i, .filter_hit_i, .overflow_i, .cnt_ctl_o
    );

    // ==========
    // expectation
    function automatic logic legal(input logic [7:0] c);
        return c <= 8'h14 && !(c inside {8'h02, 8'h03, 8'h07, 8'h0F});
    endfunction
    function automatic pets_cnt_ctl_t expect_ctl(input int n);
        pets_cnt_ctl_t e;
        logic [7:0] c;
        logic ok;
        logic msk;
        c = m_w[n][7:0];
        ok = m_wr[n] && cnt_en_i[n] && !m_w[n][16] && legal(c);
        msk = !(c inside {8'h00, 8'h01, 8'h0B, 8'h0E}) && m_ctl == 2'b01;
        e.inc = ok && (c == 8'h00 || evt_i.fire[c[4:0]] && (c == 8'h01 || filter_hit_i[n])
            && !(msk && evt_i.secure[c[4:0]]));
        e.dec = ok && c == 8'h0C && filter_hit_i[n] && evt_i.set_comp_release
            && !(msk && evt_i.release_secure);
        e.max_mode = m_w[n][17:16] == 2'b10;
        e.capture = m_wr[n] && m_w[n][31] && m_cap && overflow_i[n];
        return e;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // ==========
    // avalon master: one idle edge before each request so no signal is driven twice
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        // a slave that never answers is caught by the watchdog
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] want, input logic [31:0] m);
        bus(1'b0, a, 32'h0);
        check(rd & m, want);
    endtask

    // ==========
    // random event traffic, every cycle including bus activity and reset
    always @(posedge clk_i) begin
        evt_i <= pets_evt_t'($bits(pets_evt_t)'({$urandom, $urandom}));
        cnt_en_i <= NC'($urandom);
        filter_hit_i <= NC'($urandom);
        overflow_i <= NC'($urandom);
    end

    // outputs are registered, so each edge compares against the previous edge's inputs
    always @(posedge clk_i) begin
        if (live_q) begin
            for (int n = 0; n < NC; n++) begin
                check(cnt_ctl_o[n], exp_q[n]);
                check(cnt_ctl_o[n], exp_q[n]);
            end
        end
        if (rst_i) begin
            live_q = 1'b1;
            m_wr = '0;
            m_ctl = 2'b00;
            m_cap = 1'b0;
            m_hit = '0;
            exp_q = '0;
            for (int n = 0; n < NC; n++)
                m_w[n] = 32'h0;
        end else begin
            // status read data reflect the sticky bits at the taking edge
            if (avs_read_i && avs_waitrequest_o === 1'b1 && avs_address_i == 12'hE84)
                hit_snap = m_hit;
            if (avs_write_i && avs_waitrequest_o === 1'b0 && avs_address_i == 12'hE84)
                m_hit = m_hit & ~avs_writedata_i[NC-1:0];
            // a same-cycle increment beats the clear
            for (int n = 0; n < NC; n++)
                m_hit[n] = m_hit[n] | exp_q[n].inc;
            for (int n = 0; n < NC; n++)
                exp_q[n] = expect_ctl(n);
            if (avs_write_i && avs_waitrequest_o === 1'b0) begin
                if (avs_address_i[11:9] == 3'h2 && avs_address_i[8:2] < NC) begin
                    m_w[avs_address_i[8:2]] = avs_writedata_i;
                    m_wr[avs_address_i[8:2]] = 1'b1;
                end
                if (avs_address_i == 12'hE80)
                    m_ctl = avs_writedata_i[1:0];
                if (avs_address_i == 12'hD88)
                    m_cap = avs_writedata_i[0];
            end
        end
    end

    task automatic close_out;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        close_out();
    end

    initial begin
        void'($urandom(32'h12CFDB6D));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(12'h400, 32'h0, 32'hFFFF_FF00);
        bus(1'b1, 12'h414, 32'hFFFF_FFFF);
        bus(1'b1, 12'h410, 32'hFFFF_FFFF);
        rdchk(12'h414, 32'h0, 32'hFFFF_FFFF);
        rdchk(12'h410, 32'h8003_00FF, 32'hFFFF_FFFF);
        rdchk(12'hD88, 32'h0, 32'hFFFF_FFFF);
        rdchk(12'hFFC, 32'h0, 32'hFFFF_FFFF);
        // codes sweep 0 to 0x17 on every counter, reserved ones included
        for (int i = 0; i < 40; i++) begin
            for (int n = 0; n < NC; n++) begin
                wc[n] = $urandom;
                wc[n][7:0] = 8'((i * NC + n) % 24);
                bus(1'b1, 12'h400 + 12'(n * 4), wc[n]);
            end
            bus(1'b1, 12'hE80, $urandom);
            bus(1'b1, 12'hD88, $urandom);
            repeat (20) @(posedge clk_i);
            for (int n = 0; n < NC; n++)
                rdchk(12'h400 + 12'(n * 4), wc[n] & 32'h8003_00FF, 32'hFFFF_FFFF);
            bus(1'b0, 12'hE84, 32'h0);
            check(rd, 32'(hit_snap));
            bus(1'b1, 12'hE84, 32'h1F);
            if (i == 20) begin
                rst_i <= 1'b1;
                repeat (2) @(posedge clk_i);
                rst_i <= 1'b0;
                rdchk(12'h404, 32'h0, 32'hFFFF_FF00);
            end
        end
        close_out();
    end
endmodule

`default_nettype wire
